/* File: spi_flash_pkg.sv */
// Constants and types shared by the SPI flash pin front end
package spi_flash_pkg;

  // ==========================================================================
  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] ADDR_FIRST_STATUS = 8'h00;
  localparam logic [7:0] ADDR_SECOND_STATUS = 8'h04;
  localparam logic [7:0] ADDR_LANE_CFG = 8'h08;
  localparam logic [7:0] ADDR_OP_BUSY = 8'h0c;
  localparam logic [7:0] ADDR_TX_DATA = 8'h10;
  localparam logic [7:0] ADDR_RX_DATA = 8'h14;
  localparam logic [7:0] ADDR_LINK_STATE = 8'h18;

  // ==========================================================================
  // Values after reset
  localparam logic [7:0] FIRST_STATUS_RESET = 8'h00;
  localparam logic [7:0] SECOND_STATUS_RESET = 8'h00;
  localparam logic [2:0] LANE_CFG_RESET = 3'h0;
  localparam logic [7:0] TX_DATA_RESET = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int GUARD_LOWER_BIT = 7;
  localparam int GUARD_UPPER_BIT = 0;
  localparam int FOUR_LANE_BIT = 1;
  localparam int CFG_DIR_BIT = 2;
  localparam int REFUSED_BIT = 5;

  // Lane width field codes in the lane configuration register
  localparam logic [1:0] CFG_WIDTH_TWO = 2'h1;
  localparam logic [1:0] CFG_WIDTH_FOUR = 2'h2;

  // AHB-Lite transfer size for a whole word
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Effective number of data lanes in use
  typedef enum logic [1:0] {width_one, width_two, width_four} lane_width_t;

endpackage

/* File: spi_flash_pin_interface.sv */
// Pin front end of a serial NOR flash with AHB-Lite register access
`timescale 1ns/1ns
// Notes on behaviour
// - Select high: ignore inputs, outputs undriven
// - Deselected means standby unless operation busy
// - Select low enables device, active power mode
// - No instruction before first select falling edge
// - Input bits sampled on serial clock rise
// - Output bits change only after clock fall
// - Lane zero bidirectional in dual/quad
// - Lane one bidirectional in dual/quad
// - Hardware lock rejects status register writes
// - Hardware lock keeps protected array regions locked
// - Four-lane enable disables write-protect function
// - Write-protect pin becomes lane two in quad
// - Pause pin becomes lane three in quad
// - Pause stops link only, operations continue
// - Pause starts with select low, clock low
// - Pause ends on pin high, clock low
// - Paused: outputs undriven, clock and input ignored
// - Deselect while paused resets interface state
// - Modes 0 and 3 both supported; output here works in mode 3 only, first bit driven after the first clock fall
// - Quad only when four-lane enable set
module spi_flash_pin_interface (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic lane_zero_in,
  output logic lane_zero_out,
  output logic lane_zero_oe,
  input wire logic lane_one_in,
  output logic lane_one_out,
  output logic lane_one_oe,
  input wire logic lane_two_in,
  output logic lane_two_out,
  output logic lane_two_oe,
  input wire logic lane_three_in,
  output logic lane_three_out,
  output logic lane_three_oe
);

  // ==========================================================================
  // Declarations
  logic [5:0] pin_meta, pin_sync;
  logic [3:0] lanes_s, lane_out_q, lane_oe_q;
  logic sclk_s, cs_s, sclk_last, cs_last, sclk_rise, sclk_fall, cs_fall;
  logic four_lane_enable, hw_lock, op_busy, dir_out;
  logic armed, selected, paused, shift_en, hold_low, byte_end, write_refused;
  logic [7:0] first_status_reg, second_status_reg, tx_data, rx_shift, next_rx, rx_data;
  logic [7:0] rx_count, tx_shift, tx_cur, tx_count, addr_q;
  logic [2:0] lane_cfg, step, bit_cnt;
  logic ahb_take, wr_pend, rd_pend, wr_first, wr_second;
  logic [31:0] read_mux;
  spi_flash_pkg::lane_width_t width;

  // ==========================================================================
  // Pin synchronisers and edge detection
  // Two flops on every pin; only the second stage feeds logic
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_meta <= 6'h3f;
      pin_sync <= 6'h3f;
    end else begin
      pin_meta <= {cs_n, sclk, lane_three_in, lane_two_in, lane_one_in, lane_zero_in};
      pin_sync <= pin_meta;
    end
  end
  assign lanes_s = pin_sync[3:0];
  assign sclk_s = pin_sync[4];
  assign cs_s = pin_sync[5];
  // Previous sampled levels for edge finding
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_last <= 1'b1;
      cs_last <= 1'b1;
    end else begin
      sclk_last <= sclk_s;
      cs_last <= cs_s;
    end
  end
  // Edges are seen the same way whether the clock idles low or high
  assign sclk_rise = sclk_s & ~sclk_last;
  assign sclk_fall = ~sclk_s & sclk_last;
  assign cs_fall = ~cs_s & cs_last;

  // ==========================================================================
  // Protection and lane width decode
  assign four_lane_enable = second_status_reg[spi_flash_pkg::FOUR_LANE_BIT];
  // Lock needs pin low, upper guard clear, lower guard set, four-lane off
  assign hw_lock = ~four_lane_enable & ~lanes_s[2]
    & ~second_status_reg[spi_flash_pkg::GUARD_UPPER_BIT]
    & first_status_reg[spi_flash_pkg::GUARD_LOWER_BIT];
  assign dir_out = lane_cfg[spi_flash_pkg::CFG_DIR_BIT];
  // Quad request falls back to one lane unless four-lane enable is set
  always_comb begin
    width = spi_flash_pkg::width_one;
    step = 3'h1;
    if (lane_cfg[1:0] == spi_flash_pkg::CFG_WIDTH_FOUR && four_lane_enable) begin
      width = spi_flash_pkg::width_four;
      step = 3'h4;
    end else if (lane_cfg[1:0] == spi_flash_pkg::CFG_WIDTH_TWO) begin
      width = spi_flash_pkg::width_two;
      step = 3'h2;
    end
  end

  // ==========================================================================
  // Select, arming and pause
  // Nothing is accepted until select has fallen once after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      armed <= 1'b0;
    end else if (cs_fall) begin
      armed <= 1'b1;
    end
  end
  // Selected follows select low once armed
  always_ff @(posedge clk) begin
    if (rst) begin
      selected <= 1'b0;
    end else begin
      selected <= (armed | cs_fall) & ~cs_s;
    end
  end
  // Pause pin only acts as pause outside quad width
  assign hold_low = ~lanes_s[3] & (width != spi_flash_pkg::width_four);
  // Pause state moves only while the clock is low; deselect drops it
  always_ff @(posedge clk) begin
    if (rst) begin
      paused <= 1'b0;
    end else if (!selected) begin
      paused <= 1'b0;
    end else if (!sclk_s) begin
      paused <= hold_low;
    end
  end
  assign shift_en = selected & ~paused;

  // ==========================================================================
  // Bit counter, kept across a pause and cleared on deselect
  assign byte_end = (3'(bit_cnt + step) == 3'h0);

  always_ff @(posedge clk) begin
    if (rst || !selected) begin
      bit_cnt <= 3'h0;
    end else if (shift_en && (dir_out ? sclk_fall : sclk_rise)) begin
      bit_cnt <= 3'(bit_cnt + step);
    end
  end

  // ==========================================================================
  // Receive path: lanes sampled on serial clock rise
  always_comb begin
    unique case (width)
      spi_flash_pkg::width_one: next_rx = {rx_shift[6:0], lanes_s[0]};
      spi_flash_pkg::width_two: next_rx = {rx_shift[5:0], lanes_s[1:0]};
      spi_flash_pkg::width_four: next_rx = {rx_shift[3:0], lanes_s};
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_shift <= 8'h00;
      rx_data <= 8'h00;
      rx_count <= 8'h00;
    end else if (shift_en && !dir_out && sclk_rise) begin
      rx_shift <= next_rx;
      if (byte_end) begin
        rx_data <= next_rx;
        rx_count <= 8'(rx_count + 8'h01);
      end
    end
  end

  // ==========================================================================
  // Transmit path: new bits put out only after serial clock fall
  assign tx_cur = (bit_cnt == 3'h0) ? tx_data : tx_shift;

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_shift <= 8'h00;
      tx_count <= 8'h00;
      lane_out_q <= 4'h0;
    end else if (shift_en && dir_out && sclk_fall) begin
      tx_shift <= 8'(tx_cur << step);
      if (byte_end) begin
        tx_count <= 8'(tx_count + 8'h01);
      end
      unique case (width)
        spi_flash_pkg::width_one: lane_out_q <= {2'b00, tx_cur[7], 1'b0};
        spi_flash_pkg::width_two: lane_out_q <= {2'b00, tx_cur[7:6]};
        spi_flash_pkg::width_four: lane_out_q <= tx_cur[7:4];
      endcase
    end
  end

  // Lane drivers: off when deselected, paused or receiving
  always_ff @(posedge clk) begin
    if (rst || !shift_en || !dir_out) begin
      lane_oe_q <= 4'h0;
    end else begin
      unique case (width)
        spi_flash_pkg::width_one: lane_oe_q <= 4'b0010;
        spi_flash_pkg::width_two: lane_oe_q <= 4'b0011;
        spi_flash_pkg::width_four: lane_oe_q <= 4'b1111;
      endcase
    end
  end

  assign lane_zero_out = lane_out_q[0];
  assign lane_one_out = lane_out_q[1];
  assign lane_two_out = lane_out_q[2];
  assign lane_three_out = lane_out_q[3];
  assign lane_zero_oe = lane_oe_q[0];
  assign lane_one_oe = lane_oe_q[1];
  assign lane_two_oe = lane_oe_q[2];
  assign lane_three_oe = lane_oe_q[3];

  // ==========================================================================
  // AHB-Lite slave: zero-wait writes, one wait state on reads
  assign ahb_take = hsel & hready & htrans[1] & (hsize == spi_flash_pkg::HSIZE_WORD);

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else begin
      wr_pend <= ahb_take & hwrite;
      rd_pend <= ahb_take & ~hwrite;
      hreadyout <= ~(ahb_take & ~hwrite);
      hresp <= 1'b0;
      if (ahb_take) begin
        addr_q <= haddr[7:0];
      end
      if (rd_pend) begin
        hrdata <= read_mux;
      end
    end
  end

  // Read data; unmapped offsets read as zero
  always_comb begin
    unique case (addr_q)
      spi_flash_pkg::ADDR_FIRST_STATUS: read_mux = {24'h0, first_status_reg};
      spi_flash_pkg::ADDR_SECOND_STATUS: read_mux = {24'h0, second_status_reg};
      spi_flash_pkg::ADDR_LANE_CFG: read_mux = {29'h0, lane_cfg};
      spi_flash_pkg::ADDR_OP_BUSY: read_mux = {31'h0, op_busy};
      spi_flash_pkg::ADDR_TX_DATA: read_mux = {24'h0, tx_data};
      spi_flash_pkg::ADDR_RX_DATA: read_mux = {24'h0, rx_data};
      // Standby while deselected and idle; lock flag guards array regions
      spi_flash_pkg::ADDR_LINK_STATE: read_mux = {8'h0, tx_count, rx_count, 2'b00,
        write_refused, hw_lock, armed, paused, ~selected & ~op_busy, selected};
      default: read_mux = 32'h0000_0000;
    endcase
  end
  assign wr_first = wr_pend & (addr_q == spi_flash_pkg::ADDR_FIRST_STATUS);
  assign wr_second = wr_pend & (addr_q == spi_flash_pkg::ADDR_SECOND_STATUS);

  // Status registers; writes dropped while the hardware lock holds
  always_ff @(posedge clk) begin
    if (rst) begin
      first_status_reg <= spi_flash_pkg::FIRST_STATUS_RESET;
      second_status_reg <= spi_flash_pkg::SECOND_STATUS_RESET;
    end else if (!hw_lock) begin
      if (wr_first) begin
        first_status_reg <= hwdata[7:0];
      end
      if (wr_second) begin
        second_status_reg <= hwdata[7:0];
      end
    end
  end

  // Control registers; busy flag is untouched by select or pause
  always_ff @(posedge clk) begin
    if (rst) begin
      lane_cfg <= spi_flash_pkg::LANE_CFG_RESET;
      op_busy <= 1'b0;
      tx_data <= spi_flash_pkg::TX_DATA_RESET;
    end else if (wr_pend) begin
      if (addr_q == spi_flash_pkg::ADDR_LANE_CFG) begin
        lane_cfg <= hwdata[2:0];
      end
      if (addr_q == spi_flash_pkg::ADDR_OP_BUSY) begin
        op_busy <= hwdata[0];
      end
      if (addr_q == spi_flash_pkg::ADDR_TX_DATA) begin
        tx_data <= hwdata[7:0];
      end
    end
  end

  // Sticky refusal flag; a new refusal wins over a write-one clear
  always_ff @(posedge clk) begin
    if (rst) begin
      write_refused <= 1'b0;
    end else begin
      write_refused <= ((wr_first | wr_second) & hw_lock) | (write_refused &
        ~(wr_pend & (addr_q == spi_flash_pkg::ADDR_LINK_STATE)
        & hwdata[spi_flash_pkg::REFUSED_BIT]));
    end
  end

  // ==========================================================================
  // Assertions
  property p_desel_hiz;
    @(posedge clk) disable iff (rst) !selected |=> lane_oe_q == 4'h0;
  endproperty
  a_desel_hiz: assert property (p_desel_hiz) else $error("Lanes driven while deselected");
  property p_arm_first;
    @(posedge clk) disable iff (rst) !armed |-> !selected;
  endproperty
  a_arm_first: assert property (p_arm_first) else $error("Selected before select fell");
  property p_select;
    @(posedge clk) disable iff (rst) (!cs_s && (armed || cs_fall)) |=> selected;
  endproperty
  a_select: assert property (p_select) else $error("Select low did not enable");
  property p_rx_on_rise;
    @(posedge clk) disable iff (rst) $changed(rx_shift) |-> $past(sclk_rise) && $past(shift_en);
  endproperty
  a_rx_on_rise: assert property (p_rx_on_rise) else $error("Input sampled off rising edge");
  property p_tx_on_fall;
    @(posedge clk) disable iff (rst) $changed(lane_out_q) |-> $past(sclk_fall);
  endproperty
  a_tx_on_fall: assert property (p_tx_on_fall) else $error("Output changed off falling edge");
  property p_lock_write;
    @(posedge clk) disable iff (rst) (wr_first && hw_lock) |=> $stable(first_status_reg);
  endproperty
  a_lock_write: assert property (p_lock_write) else $error("Locked status write accepted");
  property p_four_lane_wp;
    @(posedge clk) disable iff (rst) four_lane_enable |-> !hw_lock;
  endproperty
  a_four_lane_wp: assert property (p_four_lane_wp) else $error("Lock active with four lanes");
  property p_pause_clk_low;
    @(posedge clk) disable iff (rst) ($changed(paused) && $past(selected)) |-> $past(!sclk_s);
  endproperty
  a_pause_clk_low: assert property (p_pause_clk_low) else $error("Pause moved with clock high");
  // Deselect while paused clears the counter, so only a held select counts here
  property p_pause_hiz;
    @(posedge clk) disable iff (rst) (paused && selected)
      |=> lane_oe_q == 4'h0 && $stable(bit_cnt);
  endproperty
  a_pause_hiz: assert property (p_pause_hiz) else $error("Paused link not frozen");
  property p_desel_clear;
    @(posedge clk) disable iff (rst) (paused && !selected) |=> bit_cnt == 3'h0 && !paused;
  endproperty
  a_desel_clear: assert property (p_desel_clear) else $error("Deselect kept link state");
  property p_quad_gate;
    @(posedge clk) disable iff (rst) !four_lane_enable |-> width != spi_flash_pkg::width_four;
  endproperty
  a_quad_gate: assert property (p_quad_gate) else $error("Quad width without enable");

endmodule

/* File: host_model.sv */
// Host SPI controller model driving select, serial clock and the four lanes
`timescale 1ns/1ns
module host_model (
  input wire logic clk,
  output logic cs_n,
  output logic sclk,
  output logic lane_zero_in,
  output logic lane_one_in,
  output logic lane_two_in,
  output logic lane_three_in,
  input wire logic lane_zero_out,
  input wire logic lane_one_out,
  input wire logic lane_two_out,
  input wire logic lane_three_out,
  input wire logic lane_zero_oe,
  input wire logic lane_one_oe,
  input wire logic lane_two_oe,
  input wire logic lane_three_oe
);
  // Half period of the 800 ns serial clock
  localparam int HALF = 400;
  logic [3:0] en = 4'h0;
  logic [3:0] val = 4'h0;
  logic junk = 1'b0;
  logic [3:0] p;

  // Released lanes 0 and 1 change every cycle; lanes 2 and 3 have pull-ups
  always @(posedge clk) junk <= ~junk;
  assign lane_zero_in = lane_zero_oe ? lane_zero_out : (en[0] ? val[0] : junk);
  assign lane_one_in = lane_one_oe ? lane_one_out : (en[1] ? val[1] : ~junk);
  assign lane_two_in = lane_two_oe ? lane_two_out : (en[2] ? val[2] : 1'b1);
  assign lane_three_in = lane_three_oe ? lane_three_out : (en[3] ? val[3] : 1'b1);
  assign p = {lane_three_in, lane_two_in, lane_one_in, lane_zero_in};

  // Pins idle: deselected, clock low
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
  end

  // Select is high before it is driven low
  task select();
    #37;
    cs_n = 1'b0;
    #HALF;
  endtask

  // Deselect and release every lane
  task deselect();
    #HALF;
    cs_n = 1'b1;
    en = 4'h0;
    #HALF;
  endtask

  task set_sclk(input logic v);
    #37;
    sclk = v;
    #HALF;
  endtask

  task drive(input logic [3:0] e, input logic [3:0] v);
    #37;
    en = e;
    val = v;
  endtask

  // Shift n steps of w lanes in, MSB first, lanes change while the clock is low
  task clock_in(input logic [7:0] b, input int w, input int n);
    logic [7:0] s;
    logic [3:0] c;
    s = b;
    en = (w == 4) ? 4'hf : {en[3:2], (w == 2) ? 2'h3 : 2'h1};
    for (int i = 0; i < n; i++) begin
      c = 4'(s >> (8 - w));
      val = (w == 4) ? c : {val[3:2], c[1:0]};
      #HALF;
      sclk = 1'b1;
      #HALF;
      sclk = 1'b0;
      s = s << w;
    end
  endtask

  // Mode 3 read: fall, then sample the lanes at the rise
  task clock_out(input int w, output logic [7:0] r);
    r = 8'h00;
    en = 4'h0;
    for (int i = 0; i < 8 / w; i++) begin
      sclk = 1'b0;
      #HALF;
      sclk = 1'b1;
      r = (r << w) | 8'(w == 4 ? p : (w == 2 ? p[1:0] : p[1]));
      #HALF;
    end
  endtask
endmodule

/* File: spi_flash_pin_interface_tb_top.sv */
// Self-checking testbench for the SPI flash pin front end
`timescale 1ns/1ns
module spi_flash_pin_interface_tb_top;
  // ==========================================================================
  // Signals
  logic clk, rst, hsel, hwrite, hready, hreadyout, hresp, cs_n, sclk;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic lane_zero_in, lane_one_in, lane_two_in, lane_three_in;
  logic lane_zero_out, lane_one_out, lane_two_out, lane_three_out;
  logic lane_zero_oe, lane_one_oe, lane_two_oe, lane_three_oe;
  logic [3:0] oes;
  logic [7:0] sb;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;

  // Single slave: its ready is the bus ready
  assign hready = hreadyout;
  assign oes = {lane_three_oe, lane_two_oe, lane_one_oe, lane_zero_oe};

  // ==========================================================================
  // Instances
  spi_flash_pin_interface spi_flash_pin_interface_inst (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .cs_n(cs_n), .sclk(sclk),
    .lane_zero_in(lane_zero_in), .lane_zero_out(lane_zero_out), .lane_zero_oe(lane_zero_oe),
    .lane_one_in(lane_one_in), .lane_one_out(lane_one_out), .lane_one_oe(lane_one_oe),
    .lane_two_in(lane_two_in), .lane_two_out(lane_two_out), .lane_two_oe(lane_two_oe),
    .lane_three_in(lane_three_in), .lane_three_out(lane_three_out),
    .lane_three_oe(lane_three_oe)
  );
  host_model host_model_inst (
    .clk(clk), .cs_n(cs_n), .sclk(sclk), .lane_zero_in(lane_zero_in),
    .lane_one_in(lane_one_in), .lane_two_in(lane_two_in), .lane_three_in(lane_three_in),
    .lane_zero_out(lane_zero_out), .lane_one_out(lane_one_out),
    .lane_two_out(lane_two_out), .lane_three_out(lane_three_out),
    .lane_zero_oe(lane_zero_oe), .lane_one_oe(lane_one_oe), .lane_two_oe(lane_two_oe),
    .lane_three_oe(lane_three_oe)
  );

  // ==========================================================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails++;
      finish_test();
    end
  end

  // ==========================================================================
  // Bus and compare tasks
  task addr_phase(input logic [7:0] a, input logic w, input logic [2:0] sz);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= sz;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
  endtask
  task ahb_write_sz(input logic [7:0] a, input logic [31:0] d, input logic [2:0] sz);
    addr_phase(a, 1'b1, sz);
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask
  task ahb_write(input logic [7:0] a, input logic [31:0] d);
    ahb_write_sz(a, d, spi_flash_pkg::HSIZE_WORD);
  endtask
  task ahb_read(input logic [7:0] a, output logic [31:0] d);
    addr_phase(a, 1'b0, spi_flash_pkg::HSIZE_WORD);
    do @(posedge clk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  task check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task expect_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb_read(a, rd);
    check_word(rd & m, e, "register");
    check_word({31'h0, hresp}, 32'h0, "response");
  endtask
  task settle();
    repeat (12) @(posedge clk);
  endtask

  // ==========================================================================
  // Scenarios
  task test_reset();
    expect_reg(spi_flash_pkg::ADDR_FIRST_STATUS, 32'hff, 32'h0);
    expect_reg(spi_flash_pkg::ADDR_SECOND_STATUS, 32'hff, 32'h0);
    expect_reg(spi_flash_pkg::ADDR_LANE_CFG, 32'h7, 32'h0);
    ahb_write(8'h40, 32'hffff);
    expect_reg(8'h40, 32'hffffffff, 32'h0);
    // A byte-sized write is ignored by the slave
    ahb_write_sz(spi_flash_pkg::ADDR_FIRST_STATUS, 32'hff, 3'h0);
    expect_reg(spi_flash_pkg::ADDR_FIRST_STATUS, 32'hff, 32'h0);
    host_model_inst.clock_in(8'hff, 1, 8);
    settle();
    expect_reg(spi_flash_pkg::ADDR_LINK_STATE, 32'hff0f, 32'h2);
  endtask
  task test_select();
    host_model_inst.select();
    settle();
    expect_reg(spi_flash_pkg::ADDR_LINK_STATE, 32'hb, 32'h9);
    host_model_inst.deselect();
    ahb_write(spi_flash_pkg::ADDR_OP_BUSY, 32'h1);
    settle();
    expect_reg(spi_flash_pkg::ADDR_LINK_STATE, 32'h3, 32'h0);
    ahb_write(spi_flash_pkg::ADDR_OP_BUSY, 32'h0);
    expect_reg(spi_flash_pkg::ADDR_LINK_STATE, 32'h3, 32'h2);
  endtask
  task rx_byte(input logic [7:0] b, input int w, input logic [31:0] cfg);
    ahb_write(spi_flash_pkg::ADDR_LANE_CFG, cfg);
    host_model_inst.select();
    host_model_inst.clock_in(b, w, 8 / w);
    host_model_inst.deselect();
    expect_reg(spi_flash_pkg::ADDR_RX_DATA, 32'hff, {24'h0, b});
  endtask
  task test_rx();
    rx_byte(8'ha5, 1, 32'h0);
    rx_byte(8'h3c, 2, 32'h1);
    rx_byte(8'h69, 1, 32'h2);
    ahb_write(spi_flash_pkg::ADDR_SECOND_STATUS, 32'h2);
    rx_byte(8'h96, 4, 32'h2);
    expect_reg(spi_flash_pkg::ADDR_LINK_STATE, 32'hff00, 32'h0400);
  endtask
  task test_tx();
    for (int i = 0; i < 3; i++) begin
      ahb_write(spi_flash_pkg::ADDR_LANE_CFG, 32'(4 + i));
      ahb_write(spi_flash_pkg::ADDR_TX_DATA, 32'(8'hb4 ^ 8'(i)));
      host_model_inst.set_sclk(1'b1);
      host_model_inst.select();
      host_model_inst.clock_out(1 << i, sb);
      host_model_inst.deselect();
      check_byte(sb, 8'hb4 ^ 8'(i), "tx byte");
    end
    host_model_inst.set_sclk(1'b0);
    settle();
    check_word({28'h0, oes}, 32'h0, "lane enables");
    expect_reg(spi_flash_pkg::ADDR_LINK_STATE, 32'hff0000, 32'h030000);
    ahb_write(spi_flash_pkg::ADDR_SECOND_STATUS, 32'h0);
    ahb_write(spi_flash_pkg::ADDR_LANE_CFG, 32'h0);
  endtask
  task test_lock();
    ahb_write(spi_flash_pkg::ADDR_FIRST_STATUS, 32'h80);
    host_model_inst.select();
    host_model_inst.drive(4'h4, 4'h0);
    settle();
    expect_reg(spi_flash_pkg::ADDR_LINK_STATE, 32'h10, 32'h10);
    ahb_write(spi_flash_pkg::ADDR_FIRST_STATUS, 32'h0);
    expect_reg(spi_flash_pkg::ADDR_FIRST_STATUS, 32'hff, 32'h80);
    ahb_write(spi_flash_pkg::ADDR_SECOND_STATUS, 32'h2);
    expect_reg(spi_flash_pkg::ADDR_SECOND_STATUS, 32'hff, 32'h0);
    ahb_write(spi_flash_pkg::ADDR_LINK_STATE, 32'h20);
    expect_reg(spi_flash_pkg::ADDR_LINK_STATE, 32'h20, 32'h0);
    host_model_inst.drive(4'h4, 4'h4);
    settle();
    ahb_write(spi_flash_pkg::ADDR_SECOND_STATUS, 32'h2);
    host_model_inst.drive(4'h4, 4'h0);
    settle();
    expect_reg(spi_flash_pkg::ADDR_LINK_STATE, 32'h10, 32'h0);
    ahb_write(spi_flash_pkg::ADDR_FIRST_STATUS, 32'h0);
    expect_reg(spi_flash_pkg::ADDR_FIRST_STATUS, 32'hff, 32'h0);
    ahb_write(spi_flash_pkg::ADDR_SECOND_STATUS, 32'h0);
    host_model_inst.deselect();
  endtask
  task test_pause();
    ahb_write(spi_flash_pkg::ADDR_OP_BUSY, 32'h1);
    host_model_inst.select();
    host_model_inst.clock_in(8'hc3, 1, 3);
    host_model_inst.drive(4'h1, 4'h0);
    host_model_inst.set_sclk(1'b1);
    host_model_inst.drive(4'h9, 4'h0);
    settle();
    expect_reg(spi_flash_pkg::ADDR_LINK_STATE, 32'h4, 32'h0);
    host_model_inst.set_sclk(1'b0);
    settle();
    expect_reg(spi_flash_pkg::ADDR_LINK_STATE, 32'h4, 32'h4);
    expect_reg(spi_flash_pkg::ADDR_OP_BUSY, 32'h1, 32'h1);
    host_model_inst.clock_in(8'hff, 1, 4);
    host_model_inst.set_sclk(1'b1);
    host_model_inst.drive(4'h1, 4'h0);
    settle();
    expect_reg(spi_flash_pkg::ADDR_LINK_STATE, 32'h4, 32'h4);
    host_model_inst.set_sclk(1'b0);
    settle();
    expect_reg(spi_flash_pkg::ADDR_LINK_STATE, 32'h4, 32'h0);
    host_model_inst.clock_in(8'h30, 1, 4);
    host_model_inst.deselect();
    expect_reg(spi_flash_pkg::ADDR_RX_DATA, 32'hff, 32'hc3);
    ahb_write(spi_flash_pkg::ADDR_OP_BUSY, 32'h0);
  endtask
  task test_pause_deselect();
    host_model_inst.select();
    host_model_inst.clock_in(8'he0, 1, 3);
    host_model_inst.drive(4'h9, 4'h0);
    settle();
    host_model_inst.deselect();
    host_model_inst.select();
    host_model_inst.clock_in(8'h5a, 1, 8);
    host_model_inst.deselect();
    expect_reg(spi_flash_pkg::ADDR_RX_DATA, 32'hff, 32'h5a);
  endtask

  // ==========================================================================
  // Verdict and main sequence
  task finish_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_select();
    test_rx();
    test_tx();
    test_lock();
    test_pause();
    test_pause_deselect();
    finish_test();
  end
endmodule
